/* File: rtl/card_init_regs.vh */
// Constants for the card-side initialisation and signal voltage switch logic
// Behaviour
// - Mode holds until next CMD0 or power
// - CMD8 echoes voltage and pattern, else silent
// - S18A set only if requested and switching
// - CMD11 answered with then UHS-I SDR12
// - CMD and DAT driven low after response
// - 1.8V settles within 5ms of clock stop
// - CMD driven high one clock after restart
// - DAT high one clock within 1ms
// - 1.8V survives CMD0, SPI refused afterwards
// - Relative address is nonzero, varies per access
// - CMD6 groups: speed, driver, current limit
// - Current limit 200mA default, high modes only
`ifndef CARD_INIT_REGS_VH
`define CARD_INIT_REGS_VH

// ============================================================
// Command indexes
`define CMD_GO_IDLE 6'h00
`define CMD_ALL_CID 6'h02
`define CMD_REL_ADDR 6'h03
`define CMD_SWITCH_FN 6'h06
`define CMD_SELECT 6'h07
`define CMD_IF_COND 6'h08
`define CMD_VOLT_SW 6'h0B
`define CMD_TUNING 6'h13
`define CMD_APP 6'h37
`define ACMD_BUS_WIDTH 6'h06
`define ACMD_OP_COND 6'h29
`define IDX_NONE 6'h3F

// ============================================================
// Card states; IDLE to TRAN also the status field
`define ST_IDLE 4'h0
`define ST_READY 4'h1
`define ST_IDENT 4'h2
`define ST_STBY 4'h3
`define ST_TRAN 4'h4
`define ST_VSW_LOW 4'h5
`define ST_VSW_STOP 4'h6
`define ST_VSW_CMDHI 4'h7
`define ST_VSW_DATHI 4'h8
`define ST_VSW_FAIL 4'h9

// ============================================================
// Field positions and values
`define STAT_LOCKED 25
`define STAT_RDY_DATA 8
`define STAT_APP 5
`define OCR_READY 31
`define OCR_CCS 30
`define OCR_S18A 24
`define OCR_WINDOW 24'hFF8000
`define VHS_SUPPORTED 4'h1
`define SPD_SDR12 3'h0
`define SPD_SDR50 3'h2
`define DRV_TYPE_B 2'h0
`define CUR_200MA 3'h0
`define BUS_W4 2'h2

// ============================================================
// Timing
`define CLK_NS 10
`define DUMMY_CLKS 74
`define INIT_BUSY_RESP 3
`define CLK_STOP_NS 20000
`define CLK_STOP_CYC ((`CLK_STOP_NS + `CLK_NS - 1) / `CLK_NS)
`define V18_SETTLE_MS 5
`define V18_SETTLE_CYC ((`V18_SETTLE_MS * 1000000) / `CLK_NS)

`endif

/* File: rtl/bit_sync2.v */
// Two-flop synchroniser for a group of independent level inputs
`timescale 1ns/1ps
module bit_sync2 #(
    parameter W = 1
) (
    input wire clk_i, // System clock
    input wire sys_rst_i, // Async reset, active high
    input wire [W-1:0] async_i, // Inputs from outside the domain
    output wire [W-1:0] sync_o // Synchronised levels
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            meta_ff <= {W{1'b0}};
            sync_ff <= {W{1'b0}};
        end
        else
        begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule // bit_sync2

/* File: rtl/resp_shifter.v */
// 48-bit response frame serialiser with CRC7, one bit per bus clock rising edge
`timescale 1ns/1ps
module resp_shifter (
    input wire clk_i, // System clock
    input wire sys_rst_i, // Async reset, active high
    input wire bus_rise_i, // Bus clock rising edge pulse
    input wire load_i, // Load a frame, pulse
    input wire [5:0] idx_i, // Index field
    input wire [31:0] arg_i, // Argument field
    input wire crc_en_i, // 1: CRC7, 0: all ones
    output wire bit_o, // Serial bit, registered
    output wire oe_o, // Line driven, registered
    output reg done_o // Last bit finished, pulse
);
    reg [47:0] sh_ff;
    reg [5:0] cnt_ff;
    reg oe_ff;
    wire [39:0] head;
    wire [6:0] crc;

    function [6:0] crc7;
        input [39:0] d;
        integer i;
        reg fb;
        begin
            crc7 = 7'h00;
            for (i = 39; i >= 0; i = i - 1)
            begin
                fb = d[i] ^ crc7[6];
                crc7 = {crc7[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
            end
        end
    endfunction

    assign head = {2'b00, idx_i, arg_i};
    assign crc = crc_en_i ? crc7(head) : 7'h7F;

    // ============================================================
    // Shifting; the frame starts on the edge after the load
    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sh_ff <= 48'hFFFFFFFFFFFF;
            cnt_ff <= 6'h00;
            oe_ff <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (load_i)
            begin
                sh_ff <= {head, crc, 1'b1};
                cnt_ff <= 6'd48;
            end
            else if (bus_rise_i && cnt_ff != 6'h00)
            begin
                oe_ff <= 1'b1;
                if (oe_ff)
                begin
                    sh_ff <= {sh_ff[46:0], 1'b1};
                    cnt_ff <= cnt_ff - 6'h01;
                    if (cnt_ff == 6'h01)
                    begin
                        oe_ff <= 1'b0;
                        done_o <= 1'b1;
                    end
                end
            end
        end
    end

    assign bit_o = sh_ff[47];
    assign oe_o = oe_ff;
endmodule // resp_shifter

/* File: rtl/card_init_voltage_switch.v */
// Card-side initialisation, mode selection and 3.3V to 1.8V signal switch
`timescale 1ns/1ps
`include "card_init_regs.vh"
module card_init_voltage_switch #(
    parameter SETTLE_CYC = `V18_SETTLE_CYC,
    parameter INIT_BUSY = `INIT_BUSY_RESP
) (
    input wire clk_i, // System clock, 100 MHz
    input wire sys_rst_i, // Power-on reset, async, active high
    input wire sd_clk_i, // Bus clock pin
    input wire cmd_i, // CMD line level
    input wire dat3_i, // DAT3 / card detect level
    input wire uhs_cap_i, // Card able to switch to 1.8V
    input wire reg_ok_i, // 1.8V regulator stable
    input wire locked_i, // Card is password locked
    output reg cmd_o, // CMD drive value
    output reg cmd_oe_o, // CMD driven
    output reg [3:0] dat_o, // DAT drive values
    output reg dat_oe_o, // DAT[3:0] driven
    output wire spi_mode_o, // SPI mode selected
    output wire sig18_en_o, // Regulator enable, 1.8V signalling
    output wire uhs_mode_o, // UHS-I timing in force
    output wire bus4_o, // 4-bit bus selected
    output wire [2:0] speed_o, // Bus speed mode
    output wire [1:0] drv_type_o, // Driver strength
    output wire [2:0] cur_lim_o, // Selected current limit
    output wire cur_lim_act_o, // Current limit in effect
    output wire [3:0] state_o, // Card state
    output wire [15:0] rca_o, // Relative address
    output wire cid_req_o, // Send identification, pulse
    output wire tune_req_o, // Send tuning block, pulse
    output wire vsw_fail_o // Voltage switch failed
);
    wire [3:0] sync_q;
    wire bus_clk_s;
    wire cmd_s;
    wire dat3_s;
    wire reg_ok_s;
    wire bus_rise;
    wire tx_bit;
    wire tx_oe;
    wire tx_done;
    wire in_vsw;
    wire rx_en;
    wire [5:0] rx_idx;
    wire [31:0] rx_arg;
    wire [31:0] r1_stat;
    reg bus_clk_d_ff;
    reg [6:0] dummy_cnt_ff;
    reg [46:0] rx_sh_ff;
    reg [5:0] rx_cnt_ff;
    reg cmd_vld_ff;
    reg [3:0] state_ff;
    reg app_ff;
    reg spi_ff;
    reg v18_ff;
    reg sig18_ff;
    reg uhs_ff;
    reg s18r_ff;
    reg s18a_ff;
    reg [7:0] busy_cnt_ff;
    reg vsw_pend_ff;
    reg [15:0] rca_ff;
    reg [15:0] lfsr_ff;
    reg bus4_ff;
    reg [2:0] speed_ff;
    reg [1:0] drv_ff;
    reg [2:0] cur_ff;
    reg cid_req_ff;
    reg tune_req_ff;
    reg fail_ff;
    reg tx_load_ff;
    reg [5:0] tx_idx_ff;
    reg [31:0] tx_arg_ff;
    reg tx_crc_ff;
    reg vcmd_ff;
    reg vcmd_oe_ff;
    reg [31:0] tmr_ff;

    // ============================================================
    // Pin synchronisers and bus clock edge detection
    bit_sync2 #(.W(4)) u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i({sd_clk_i, cmd_i, dat3_i, reg_ok_i}),
        .sync_o(sync_q)
    );
    assign bus_clk_s = sync_q[3];
    assign cmd_s = sync_q[2];
    assign dat3_s = sync_q[1];
    assign reg_ok_s = sync_q[0];
    assign bus_rise = bus_clk_s & ~bus_clk_d_ff;

    resp_shifter u_tx (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .bus_rise_i(bus_rise),
        .load_i(tx_load_ff),
        .idx_i(tx_idx_ff),
        .arg_i(tx_arg_ff),
        .crc_en_i(tx_crc_ff),
        .bit_o(tx_bit),
        .oe_o(tx_oe),
        .done_o(tx_done)
    );

    assign in_vsw = (state_ff >= `ST_VSW_LOW);
    assign rx_en = (dummy_cnt_ff == `DUMMY_CLKS) && !tx_oe && !tx_load_ff && !vsw_pend_ff && !in_vsw;
    assign rx_idx = rx_sh_ff[45:40];
    assign rx_arg = rx_sh_ff[39:8];

    function [31:0] status;
        input locked;
        input [3:0] st;
        input app;
        begin
            status = 32'h0;
            status[`STAT_LOCKED] = locked;
            status[12:9] = (st > `ST_TRAN) ? `ST_READY : st;
            status[`STAT_RDY_DATA] = 1'b1;
            status[`STAT_APP] = app;
        end
    endfunction
    assign r1_stat = status(locked_i, state_ff, app_ff);

    // ============================================================
    // Dummy clock count and command frame capture
    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            bus_clk_d_ff <= 1'b0;
            dummy_cnt_ff <= 7'h00;
            rx_sh_ff <= 47'h0;
            rx_cnt_ff <= 6'h00;
            cmd_vld_ff <= 1'b0;
        end
        else
        begin
            bus_clk_d_ff <= bus_clk_s;
            cmd_vld_ff <= 1'b0;
            if (bus_rise && dummy_cnt_ff != `DUMMY_CLKS)
                dummy_cnt_ff <= dummy_cnt_ff + 7'h01;
            if (bus_rise && rx_en)
            begin
                if (rx_cnt_ff == 6'h00)
                begin
                    if (!cmd_s)
                        rx_cnt_ff <= 6'h01;
                end
                else
                begin
                    rx_sh_ff <= {rx_sh_ff[45:0], cmd_s};
                    if (rx_cnt_ff == 6'd47)
                    begin
                        rx_cnt_ff <= 6'h00;
                        cmd_vld_ff <= 1'b1;
                    end
                    else
                        rx_cnt_ff <= rx_cnt_ff + 6'h01;
                end
            end
        end
    end

    // ============================================================
    // Command handling and voltage switch sequence
    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_ff <= `ST_IDLE;
            app_ff <= 1'b0;
            spi_ff <= 1'b0;
            v18_ff <= 1'b0;
            sig18_ff <= 1'b0;
            uhs_ff <= 1'b0;
            s18r_ff <= 1'b0;
            s18a_ff <= 1'b0;
            busy_cnt_ff <= 8'h00;
            vsw_pend_ff <= 1'b0;
            rca_ff <= 16'h0000;
            lfsr_ff <= 16'hACE1;
            bus4_ff <= 1'b0;
            speed_ff <= `SPD_SDR12;
            drv_ff <= `DRV_TYPE_B;
            cur_ff <= `CUR_200MA;
            cid_req_ff <= 1'b0;
            tune_req_ff <= 1'b0;
            fail_ff <= 1'b0;
            tx_load_ff <= 1'b0;
            tx_idx_ff <= 6'h00;
            tx_arg_ff <= 32'h0;
            tx_crc_ff <= 1'b1;
            vcmd_ff <= 1'b1;
            vcmd_oe_ff <= 1'b0;
            tmr_ff <= 32'h0;
            cmd_o <= 1'b1;
            cmd_oe_o <= 1'b0;
            dat_o <= 4'hF;
            dat_oe_o <= 1'b0;
        end
        else
        begin
            tx_load_ff <= 1'b0;
            cid_req_ff <= 1'b0;
            tune_req_ff <= 1'b0;
            tx_crc_ff <= 1'b1;
            // Free-running so the address differs per access
            lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
            cmd_o <= tx_oe ? tx_bit : vcmd_ff;
            cmd_oe_o <= tx_oe | vcmd_oe_ff;

            if (cmd_vld_ff && rx_sh_ff[46] && rx_sh_ff[0])
            begin
                app_ff <= 1'b0;
                tx_idx_ff <= rx_idx;
                tx_arg_ff <= r1_stat;
                if (rx_idx == `CMD_GO_IDLE && !app_ff)
                begin
                    state_ff <= `ST_IDLE;
                    busy_cnt_ff <= 8'h00;
                    s18a_ff <= 1'b0;
                    bus4_ff <= 1'b0;
                    spi_ff <= ~dat3_s & ~v18_ff;
                end
                // SPI mode keeps this logic out
                else if (spi_ff)
                    state_ff <= state_ff;
                else if (app_ff && rx_idx == `ACMD_OP_COND && state_ff == `ST_IDLE)
                begin
                    tx_idx_ff <= `IDX_NONE;
                    tx_crc_ff <= 1'b0;
                    tx_load_ff <= 1'b1;
                    tx_arg_ff <= {8'h00, `OCR_WINDOW};
                    if (rx_arg[23:0] != 24'h0)
                    begin
                        if (busy_cnt_ff == 8'h00)
                            s18r_ff <= rx_arg[`OCR_S18A];
                        if (busy_cnt_ff + 8'h01 >= INIT_BUSY[7:0])
                        begin
                            state_ff <= `ST_READY;
                            tx_arg_ff[`OCR_READY] <= 1'b1;
                            tx_arg_ff[`OCR_CCS] <= 1'b1;
                            // grant only if asked and able
                            tx_arg_ff[`OCR_S18A] <= s18r_or_first(busy_cnt_ff, s18r_ff, rx_arg[`OCR_S18A])
                                & uhs_cap_i & ~v18_ff;
                            s18a_ff <= s18r_or_first(busy_cnt_ff, s18r_ff, rx_arg[`OCR_S18A])
                                & uhs_cap_i & ~v18_ff;
                        end
                        else
                            busy_cnt_ff <= busy_cnt_ff + 8'h01;
                    end
                end
                else if (app_ff && rx_idx == `ACMD_BUS_WIDTH && state_ff == `ST_TRAN)
                begin
                    bus4_ff <= (rx_arg[1:0] == `BUS_W4);
                    tx_load_ff <= 1'b1;
                end
                else if (rx_idx == `CMD_APP)
                begin
                    app_ff <= 1'b1;
                    tx_arg_ff[`STAT_APP] <= 1'b1;
                    tx_load_ff <= 1'b1;
                end
                else if (rx_idx == `CMD_IF_COND && state_ff == `ST_IDLE)
                begin
                    if (rx_arg[11:8] == `VHS_SUPPORTED)
                    begin
                        tx_arg_ff <= {20'h0, rx_arg[11:0]};
                        tx_load_ff <= 1'b1;
                    end
                end
                // answer only after a granted S18A
                else if (rx_idx == `CMD_VOLT_SW && state_ff == `ST_READY && s18a_ff)
                begin
                    tx_load_ff <= 1'b1;
                    vsw_pend_ff <= 1'b1;
                    s18a_ff <= 1'b0;
                end
                else if (rx_idx == `CMD_ALL_CID && state_ff == `ST_READY)
                begin
                    state_ff <= `ST_IDENT;
                    cid_req_ff <= 1'b1;
                end
                else if (rx_idx == `CMD_REL_ADDR && (state_ff == `ST_IDENT || state_ff == `ST_STBY))
                begin
                    state_ff <= `ST_STBY;
                    rca_ff <= (lfsr_ff == 16'h0000) ? 16'h0001 : lfsr_ff;
                    tx_arg_ff <= {((lfsr_ff == 16'h0000) ? 16'h0001 : lfsr_ff), 3'b000, r1_stat[12:0]};
                    tx_load_ff <= 1'b1;
                end
                else if (rx_idx == `CMD_SELECT)
                begin
                    if (rx_arg[31:16] == rca_ff && state_ff == `ST_STBY)
                    begin
                        state_ff <= `ST_TRAN;
                        tx_load_ff <= 1'b1;
                    end
                    else if (rx_arg[31:16] != rca_ff && state_ff == `ST_TRAN)
                        state_ff <= `ST_STBY;
                end
                // groups 1, 3 and 4 when setting
                else if (rx_idx == `CMD_SWITCH_FN && state_ff == `ST_TRAN)
                begin
                    if (rx_arg[31] && rx_arg[3:0] != 4'hF)
                        speed_ff <= rx_arg[2:0];
                    if (rx_arg[31] && rx_arg[11:8] != 4'hF)
                        drv_ff <= rx_arg[9:8];
                    if (rx_arg[31] && rx_arg[15:12] != 4'hF)
                        cur_ff <= rx_arg[14:12];
                    tx_load_ff <= 1'b1;
                end
                else if (rx_idx == `CMD_TUNING && state_ff == `ST_TRAN)
                begin
                    tune_req_ff <= 1'b1;
                    tx_load_ff <= 1'b1;
                end
            end

            case (state_ff)
                `ST_READY:
                begin
                    // pull lines low right after response
                    if (vsw_pend_ff && tx_done)
                    begin
                        vsw_pend_ff <= 1'b0;
                        state_ff <= `ST_VSW_LOW;
                        vcmd_ff <= 1'b0;
                        vcmd_oe_ff <= 1'b1;
                        dat_o <= 4'h0;
                        dat_oe_o <= 1'b1;
                        tmr_ff <= 32'h0;
                    end
                end
                `ST_VSW_LOW:
                begin
                    // Clock stop is seen as no edge for a long idle spell
                    if (bus_rise)
                        tmr_ff <= 32'h0;
                    else if (tmr_ff == `CLK_STOP_CYC)
                    begin
                        state_ff <= `ST_VSW_STOP;
                        sig18_ff <= 1'b1;
                        tmr_ff <= 32'h0;
                    end
                    else
                        tmr_ff <= tmr_ff + 32'h1;
                end
                `ST_VSW_STOP:
                begin
                    if (tmr_ff != SETTLE_CYC)
                        tmr_ff <= tmr_ff + 32'h1;
                    else if (!reg_ok_s)
                        fail_ff <= 1'b1;
                    if (bus_rise)
                    begin
                        state_ff <= `ST_VSW_CMDHI;
                        vcmd_ff <= 1'b1;
                    end
                end
                `ST_VSW_CMDHI:
                begin
                    if (bus_rise)
                    begin
                        vcmd_oe_ff <= 1'b0;
                        // DAT high one clock on success
                        if (reg_ok_s && !fail_ff)
                        begin
                            dat_o <= 4'hF;
                            state_ff <= `ST_VSW_DATHI;
                        end
                        else
                        begin
                            fail_ff <= 1'b1;
                            state_ff <= `ST_VSW_FAIL;
                        end
                    end
                end
                `ST_VSW_DATHI:
                begin
                    if (bus_rise)
                    begin
                        dat_oe_o <= 1'b0;
                        v18_ff <= 1'b1;
                        uhs_ff <= 1'b1;
                        speed_ff <= `SPD_SDR12;
                        state_ff <= `ST_READY;
                    end
                end
                `ST_VSW_FAIL:
                    // DAT stays low so the host sees the failure until power cycle
                    state_ff <= `ST_VSW_FAIL;
                default:
                    vcmd_oe_ff <= 1'b0;
            endcase
        end
    end

    function s18r_or_first;
        input [7:0] cnt;
        input held;
        input now;
        begin
            s18r_or_first = (cnt == 8'h00) ? now : held;
        end
    endfunction

    assign spi_mode_o = spi_ff;
    assign sig18_en_o = sig18_ff;
    assign uhs_mode_o = uhs_ff;
    assign bus4_o = bus4_ff;
    assign speed_o = speed_ff;
    assign drv_type_o = drv_ff;
    assign cur_lim_o = cur_ff;
    // limit acts in SDR50 and faster only
    assign cur_lim_act_o = uhs_ff && (speed_ff >= `SPD_SDR50);
    assign state_o = state_ff;
    assign rca_o = rca_ff;
    assign cid_req_o = cid_req_ff;
    assign tune_req_o = tune_req_ff;
    assign vsw_fail_o = fail_ff;
endmodule // card_init_voltage_switch

/* File: sim/card_init_assertions.sv */
// Checker on the card init and voltage switch ports
`timescale 1ns/1ps
module card_init_checker #(parameter SETTLE_CYC = 1, parameter INIT_BUSY = 1) (
    input wire clk_i, sys_rst_i, cmd_o, cmd_oe_o, dat_oe_o, spi_mode_o, sig18_en_o,
    input wire uhs_mode_o, cur_lim_act_o, cid_req_o, input wire [3:0] dat_o, state_o,
    input wire [2:0] speed_o, input wire [15:0] rca_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // ============================================
    // Output relations
    AST_RST_QUIET: assert property ($fell(sys_rst_i) |-> !cmd_oe_o && !dat_oe_o && state_o == 4'h0)
        else $error("Lines busy after reset");
    AST_VSW_LOW: assert property (state_o == 4'h6 |-> cmd_oe_o && !cmd_o && dat_oe_o && dat_o == 4'h0)
        else $error("Lines not low in stop");
    AST_DAT_HI: assert property (dat_oe_o && dat_o == 4'hF |-> sig18_en_o)
        else $error("DAT high at 3.3V");
    AST_S18_HOLD: assert property (sig18_en_o |=> sig18_en_o)
        else $error("1.8V dropped");
    AST_NO_SPI: assert property (sig18_en_o |-> !spi_mode_o)
        else $error("SPI at 1.8V");
    AST_UHS_18: assert property (uhs_mode_o |-> sig18_en_o)
        else $error("UHS at 3.3V");
    AST_RCA_NZ: assert property (state_o == 4'h3 |-> rca_o != 16'h0)
        else $error("Zero address");
    AST_CUR_ACT: assert property (cur_lim_act_o == (uhs_mode_o && speed_o >= 3'h2))
        else $error("Limit activity wrong");
    COV_UHS: cover property ($rose(uhs_mode_o));
    COV_LIM: cover property ($rose(cur_lim_act_o));
    COV_CID: cover property (cid_req_o);
endmodule // card_init_checker

bind card_init_voltage_switch card_init_checker #(.SETTLE_CYC(SETTLE_CYC), .INIT_BUSY(INIT_BUSY)) chk (.*);

/* File: sim/sd_host_model.sv */
// Host model: bus clock, command frames, response capture
`timescale 1ns/1ps
module sd_host_model (
    output reg sd_clk_o = 1'h0, // Bus clock, idles low
    output reg line_o = 1'h1, // CMD level, pull-up when released
    input wire cmd_i // Resolved CMD line
);
    reg s;
    reg [47:0] f;
    // ============================================
    // Bus cycles
    // clock only on request
    task tick(input integer n);
        repeat (n)
        begin
            #62.5 sd_clk_o = 1'h1;
            s = cmd_i;
            #62.5 sd_clk_o = 1'h0;
        end
    endtask
    task send(input [5:0] idx, input [31:0] arg, output reg got, output reg [31:0] rsp);
        f = {2'h1, idx, arg, 8'h01};
        repeat (48)
        begin
            line_o = f[47];
            f = f << 1;
            tick(1);
        end
        line_o = 1'h1;
        got = 1'h0;
        repeat (64)
            if (!got)
            begin
                tick(1);
                got = !s;
            end
        if (got)
            repeat (47)
            begin
                tick(1);
                f = {f[46:0], s};
            end
        rsp = f[39:8];
        // one trailing clock for CMD11, then none while the switch runs
        tick(idx == 6'h0B ? 1 : 8);
    endtask
endmodule // sd_host_model

/* File: sim/tb.sv */
// Bench: power-up, mode select, voltage switch and identification
`timescale 1ns/1ps
module tb;
    reg clk_i = 1'h0, sys_rst_i = 1'h1, dat3_h = 1'h1, got, cmd_hi = 1'h0, dat_hi = 1'h0;
    reg [31:0] r;
    reg reg_ok_i = 1'h1, locked_i = 1'h1;
    reg [1:0] seen_req = 2'h0;
    integer n_mismatch = 0, n_tests = 0, cyc = 0, k;
    wire cmd_o, cmd_oe_o, dat_oe_o, spi_mode_o, sig18_en_o, uhs_mode_o, bus4_o, cur_lim_act_o;
    wire cid_req_o, tune_req_o, vsw_fail_o, sd_clk_i, h_d;
    wire [3:0] dat_o, state_o;
    wire [2:0] speed_o, cur_lim_o;
    wire [1:0] drv_type_o;
    wire [15:0] rca_o;
    wire uhs_cap_i = 1'h1;
    // Card wins the shared lines while it drives
    wire cmd_i = cmd_oe_o ? cmd_o : h_d;
    wire dat3_i = dat_oe_o ? dat_o[3] : dat3_h;
    card_init_voltage_switch #(.SETTLE_CYC(200)) dut (.*);
    sd_host_model host (.sd_clk_o(sd_clk_i), .line_o(h_d), .cmd_i(cmd_i));
    always #5 clk_i = ~clk_i;
    // ============================================
    // Tasks and monitor
    task cmd(input [5:0] i, input [31:0] a);
        host.send(i, a, got, r);
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task complete_run;
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task op_cond;
        for (k = 0; k < 3; k = k + 1)
        begin
            cmd(6'h37, 32'h0);
            cmd(6'h29, 32'h41FF8000);
            check(r[31], k == 2);
        end
    endtask
    always @(posedge clk_i)
    begin
        cyc = cyc + 1;
        cmd_hi <= cmd_hi | sig18_en_o & cmd_oe_o & cmd_o;
        dat_hi <= dat_hi | dat_oe_o & (&dat_o);
        seen_req <= seen_req | {cid_req_o, tune_req_o};
        if (cyc == 80000)
        begin
            n_mismatch = n_mismatch + 1;
            complete_run;
        end
    end
    initial
    begin
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'h0;
        host.tick(80);
        cmd(6'h00, 32'h0);
        check(spi_mode_o, 1'h0);
        cmd(6'h08, 32'h2AA);
        check(got, 1'h0);
        cmd(6'h08, 32'h1AA);
        check(r, 32'h1AA);
        op_cond;
        check({r[30], r[24]}, 2'h3);
        cmd(6'h0B, 32'h0);
        check(got, 1'h1);
        repeat (2500) @(negedge clk_i);
        check(sig18_en_o, 1'h1);
        check({cmd_i, dat3_i}, 2'h0);
        host.tick(8);
        check({cmd_hi, dat_hi, cmd_oe_o, dat_oe_o, vsw_fail_o}, 5'h18);
        check({uhs_mode_o, speed_o, cur_lim_act_o, cur_lim_o, drv_type_o}, 10'h200);
        cmd(6'h02, 32'h0);
        cmd(6'h03, 32'h0);
        check(r[31:16] != 16'h0 && r[31:16] === rca_o, 1'h1);
        cmd(6'h07, {rca_o, 16'h0});
        check({r[25], state_o}, 5'h14);
        @(negedge clk_i) locked_i = 1'h0;
        cmd(6'h06, 32'h80FF11F2);
        check({speed_o, cur_lim_act_o, cur_lim_o, drv_type_o}, 9'h0A5);
        cmd(6'h06, 32'h00FFFFF0);
        check(speed_o, 3'h2);
        cmd(6'h37, {rca_o, 16'h0});
        cmd(6'h06, 32'h2);
        check({bus4_o, r[25]}, 2'h2);
        cmd(6'h13, 32'h0);
        check({seen_req, got}, 3'h7);
        @(negedge clk_i) dat3_h = 1'h0;
        cmd(6'h00, 32'h0);
        check({spi_mode_o, sig18_en_o, state_o}, 6'h10);
        // Power cycle: SPI allowed again, then a switch with a bad regulator
        @(negedge clk_i) sys_rst_i = 1'h1;
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'h0;
        host.tick(80);
        cmd(6'h00, 32'h0);
        check({spi_mode_o, sig18_en_o}, 2'h2);
        @(negedge clk_i) dat3_h = 1'h1;
        cmd(6'h08, 32'h1AA);
        check(got, 1'h0);
        cmd(6'h00, 32'h0);
        cmd(6'h08, 32'h1AA);
        check({spi_mode_o, r[30:0]}, 32'h1AA);
        op_cond;
        @(negedge clk_i) reg_ok_i = 1'h0;
        cmd(6'h0B, 32'h0);
        repeat (2500) @(negedge clk_i);
        host.tick(8);
        check({vsw_fail_o, state_o, dat_oe_o, dat_o, uhs_mode_o}, 11'h660);
        complete_run;
    end
endmodule // tb
